/* verilog/becs_pkg.sv */
// constants and types shared by the branch/execute cycle sequencer
package becs_pkg;

  // ----------------------------------------------------------------
  // opcode field, instr[15:6]; values picked for this block
  // ----------------------------------------------------------------
  localparam logic [9:0] BECS_OP_EXEC = 10'h010;
  localparam logic [9:0] BECS_OP_BRANCH = 10'h011;
  localparam logic [9:0] BECS_OP_LINK = 10'h012;
  localparam logic [9:0] BECS_OP_CTXSW = 10'h013;

  // ----------------------------------------------------------------
  // workspace register numbers and address arithmetic
  // ----------------------------------------------------------------
  localparam logic [3:0] BECS_WR_LINK = 4'hb;
  localparam logic [3:0] BECS_WR_OLD_WP = 4'hd;
  localparam logic [3:0] BECS_WR_OLD_PC = 4'he;
  localparam logic [3:0] BECS_WR_STATUS = 4'hf;
  localparam logic [15:0] BECS_PC_INC = 16'h0002;
  localparam logic [15:0] BECS_VEC_PC_OFS = 16'h0002;

  // ----------------------------------------------------------------
  // reset values and step numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] BECS_RST_WORD = 16'h0000;
  localparam logic [7:0] BECS_STEP_FETCH = 8'h01;
  localparam logic [7:0] BECS_STEP_DECODE = 8'h02;
  localparam logic [7:0] BECS_STEP_BASE = 8'h03;
  localparam logic [3:0] BECS_RST_COUNT = 4'h0;

  typedef enum logic [3:0] {
    BECS_IDLE, BECS_FETCH, BECS_DECODE, BECS_DERIV, BECS_ALU3,
    BECS_BL4, BECS_BL5W,
    BECS_BW4, BECS_BW5W, BECS_BW6, BECS_BW7W, BECS_BW8, BECS_BW9W,
    BECS_BW10, BECS_BW11R, BECS_BW12
  } becs_state_t;

  // byte address of workspace register n
  function automatic logic [15:0] becs_wr_addr(input logic [15:0] wp, input logic [3:0] n);
    becs_wr_addr = wp + {11'h000, n, 1'b0};
  endfunction

endpackage

/* verilog/becs_deriv_if.sv */
// link between the sequencer and its operand-derivation timer
interface becs_deriv_if;
  logic start;
  logic [3:0] ns_count;
  logic hold;
  logic busy;
  logic last;

  modport seq (output start, output ns_count, output hold, input busy, input last);
  modport timer (input start, input ns_count, input hold, output busy, output last);
endinterface

/* verilog/becs_deriv_timer.sv */
// counts the operand-derivation cycles inserted after the decode step
module becs_deriv_timer
  import becs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  becs_deriv_if.timer dif
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (dif.start) begin
      next_cnt = dif.ns_count;
    end else if (cnt != BECS_RST_COUNT && !dif.hold) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= BECS_RST_COUNT;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign dif.busy = (cnt != BECS_RST_COUNT);
  assign dif.last = (cnt == 4'h1) && !dif.hold;

  a_count_down: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dif.busy && !dif.hold && !dif.start) |=> (cnt == $past(cnt) - 4'h1)) // see (RULE_02)
    else $error("derivation count did not step down");

endmodule // becs_deriv_timer

/* verilog/becs_sequencer.sv */
// machine-cycle sequencer for execute, branch, branch-and-link and context-switch branch
//
// How it works
// (RULE_01) execute runs the operand's instruction sequence next
// (RULE_02) insert operand_derivation_cycles after fetch and ALU
// (RULE_03) plain branch fetches operand, ends one ALU
// (RULE_04) link: ALU at link_register, write PC+2
// (RULE_05) context switch writes status to register 15
// (RULE_06) context switch writes PC+2 to register 14
// (RULE_07) step 8+Ns ALU already addresses register 13
// (RULE_08) step 9+Ns writes old pointer to 13
// (RULE_09) then ALU, vector PC read, final ALU
// (RULE_10) every sequence: fetch at PC, then ALU
module becs_sequencer
  import becs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] pc,
  input wire logic [15:0] wp,
  input wire logic [15:0] status_reg,
  input wire logic [3:0] operand_derivation_cycles,
  input wire logic [15:0] source_operand_value,
  input wire logic [15:0] source_addr,
  input wire logic [15:0] deriv_addr,
  input wire logic [15:0] deriv_data,
  input wire logic deriv_rd,
  input wire logic deriv_wr,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] addr_bus,
  output logic [15:0] data_bus_value,
  output logic mem_rd,
  output logic mem_wr,
  output logic alu_cycle,
  output logic [7:0] step_num,
  output logic seq_busy,
  output logic seq_done,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic wp_load,
  output logic [15:0] wp_value
);

  becs_deriv_if dif ();

  becs_deriv_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .dif(dif)
  );

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  becs_state_t state, next_state;
  logic [15:0] instr, next_instr;
  logic [15:0] sd, next_sd;
  logic [15:0] sa, next_sa;
  logic [15:0] bus_a, next_bus_a;
  logic [15:0] bus_d, next_bus_d;
  logic bus_rd, next_bus_rd;
  logic bus_wr, next_bus_wr;
  logic [7:0] next_step;
  logic next_done, next_pc_load, next_wp_load;
  logic [15:0] next_pc_value, next_wp_value;
  logic [15:0] ret_addr;
  logic mem_wait;
  logic deriv_mem;

  assign ret_addr = pc + BECS_PC_INC;
  // memory cycles stretch until the memory answers
  assign mem_wait = (bus_rd || bus_wr) && !mem_ready;
  assign deriv_mem = (deriv_rd || deriv_wr) && !mem_ready;
  assign dif.ns_count = operand_derivation_cycles;
  assign dif.hold = (state == BECS_DERIV) && deriv_mem;
  assign dif.start = (state == BECS_DECODE);

  always_comb begin
    next_state = state;
    next_instr = instr;
    next_sd = sd;
    next_sa = sa;
    next_step = step_num;
    next_done = 1'b0;
    next_pc_load = 1'b0;
    next_wp_load = 1'b0;
    next_pc_value = pc_value;
    next_wp_value = wp_value;
    case (state)
      BECS_IDLE: begin
        if (start) begin
          next_state = BECS_FETCH;
        end
      end
      BECS_FETCH: begin
        if (!mem_wait) begin
          next_instr = mem_rdata; // see (RULE_10)
          next_state = BECS_DECODE;
        end
      end
      BECS_DECODE: begin
        // register-direct operands need no derivation cycles
        if (operand_derivation_cycles == BECS_RST_COUNT) begin
          next_sd = source_operand_value;
          next_sa = source_addr;
          next_state = BECS_ALU3;
        end else begin
          next_state = BECS_DERIV; // see (RULE_02)
        end
      end
      BECS_DERIV: begin
        if (dif.last) begin
          next_sd = source_operand_value; // see (RULE_03) (RULE_04)
          next_sa = source_addr;
          next_state = BECS_ALU3;
        end
      end
      BECS_ALU3: begin
        case (instr[15:6])
          BECS_OP_EXEC: begin
            // the operand word is already here, so no second fetch
            next_instr = sd; // see (RULE_01)
            next_state = BECS_DECODE;
          end
          BECS_OP_LINK: next_state = BECS_BL4;
          BECS_OP_CTXSW: next_state = BECS_BW4;
          default: begin
            next_pc_load = (instr[15:6] == BECS_OP_BRANCH); // see (RULE_03)
            next_pc_value = sa;
            next_done = 1'b1;
            next_state = BECS_IDLE;
          end
        endcase
      end
      BECS_BL4: next_state = BECS_BL5W;
      BECS_BL5W: begin
        if (!mem_wait) begin
          next_pc_load = 1'b1;
          next_pc_value = sa;
          next_done = 1'b1;
          next_state = BECS_IDLE;
        end
      end
      BECS_BW4: next_state = BECS_BW5W;
      BECS_BW5W: if (!mem_wait) next_state = BECS_BW6;
      BECS_BW6: next_state = BECS_BW7W;
      BECS_BW7W: if (!mem_wait) next_state = BECS_BW8;
      BECS_BW8: next_state = BECS_BW9W;
      BECS_BW9W: if (!mem_wait) next_state = BECS_BW10;
      BECS_BW10: next_state = BECS_BW11R;
      BECS_BW11R: begin
        if (!mem_wait) begin
          next_pc_value = mem_rdata; // see (RULE_09)
          next_state = BECS_BW12;
        end
      end
      BECS_BW12: begin
        next_pc_load = 1'b1;
        next_wp_load = 1'b1;
        next_wp_value = sd;
        next_done = 1'b1;
        next_state = BECS_IDLE;
      end
      default: next_state = BECS_IDLE;
    endcase
    // step numbering follows the cycle tables; derivation cycles count one each
    if (next_state == BECS_FETCH && state != BECS_FETCH) begin
      next_step = BECS_STEP_FETCH;
    end else if (next_state == BECS_DECODE && state == BECS_ALU3) begin
      next_step = BECS_STEP_DECODE;
    end else if (next_state != state || (state == BECS_DERIV && !deriv_mem)) begin
      next_step = step_num + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // bus contents for the cycle being entered; hold means no change
  // ----------------------------------------------------------------
  always_comb begin
    next_bus_a = bus_a;
    next_bus_d = bus_d;
    next_bus_rd = 1'b0;
    next_bus_wr = 1'b0;
    if (next_state != state) begin
      case (next_state)
        BECS_FETCH: begin
          next_bus_a = pc; // see (RULE_10)
          next_bus_rd = 1'b1;
        end
        // the operand is not derived yet, so the decode cycle shows the input as it stands
        BECS_DECODE: next_bus_d = source_operand_value;
        BECS_ALU3, BECS_BW10, BECS_BW12: next_bus_d = next_sd;
        BECS_BL4: begin
          next_bus_a = becs_wr_addr(wp, BECS_WR_LINK); // see (RULE_04)
          next_bus_d = next_sd;
        end
        BECS_BL5W: begin
          next_bus_d = ret_addr; // see (RULE_04)
          next_bus_wr = 1'b1;
        end
        BECS_BW4: next_bus_a = becs_wr_addr(sd, BECS_WR_STATUS);
        BECS_BW5W: begin
          next_bus_d = status_reg; // see (RULE_05)
          next_bus_wr = 1'b1;
        end
        BECS_BW6: next_bus_d = ret_addr;
        BECS_BW7W: begin
          next_bus_a = becs_wr_addr(sd, BECS_WR_OLD_PC); // see (RULE_06)
          next_bus_d = ret_addr;
          next_bus_wr = 1'b1;
        end
        BECS_BW8: begin
          next_bus_a = becs_wr_addr(sd, BECS_WR_OLD_WP); // see (RULE_07)
          next_bus_d = sd;
        end
        BECS_BW9W: begin
          next_bus_d = wp; // see (RULE_08)
          next_bus_wr = 1'b1;
        end
        BECS_BW11R: begin
          next_bus_a = sa + BECS_VEC_PC_OFS; // see (RULE_09)
          next_bus_rd = 1'b1;
        end
        default: begin
          next_bus_a = bus_a;
        end
      endcase
    end else begin
      next_bus_rd = bus_rd && mem_wait;
      next_bus_wr = bus_wr && mem_wait;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= BECS_IDLE;
      instr <= BECS_RST_WORD;
      sd <= BECS_RST_WORD;
      sa <= BECS_RST_WORD;
      bus_a <= BECS_RST_WORD;
      bus_d <= BECS_RST_WORD;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      step_num <= 8'h00;
      seq_done <= 1'b0;
      pc_load <= 1'b0;
      wp_load <= 1'b0;
      pc_value <= BECS_RST_WORD;
      wp_value <= BECS_RST_WORD;
    end else begin
      state <= next_state;
      instr <= next_instr;
      sd <= next_sd;
      sa <= next_sa;
      bus_a <= next_bus_a;
      bus_d <= next_bus_d;
      bus_rd <= next_bus_rd;
      bus_wr <= next_bus_wr;
      step_num <= next_step;
      seq_done <= next_done;
      pc_load <= next_pc_load;
      wp_load <= next_wp_load;
      pc_value <= next_pc_value;
      wp_value <= next_wp_value;
    end
  end

  // ----------------------------------------------------------------
  // outputs; the external derivation logic owns the bus meanwhile
  // ----------------------------------------------------------------
  assign addr_bus = (state == BECS_DERIV) ? deriv_addr : bus_a;
  assign data_bus_value = (state == BECS_DERIV) ? deriv_data : bus_d;
  assign mem_rd = (state == BECS_DERIV) ? deriv_rd : bus_rd;
  assign mem_wr = (state == BECS_DERIV) ? deriv_wr : bus_wr;
  assign alu_cycle = (state != BECS_IDLE) && !mem_rd && !mem_wr;
  assign seq_busy = (state != BECS_IDLE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] ns_seen;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ns_seen <= BECS_RST_COUNT;
    end else if (state == BECS_DECODE) begin
      ns_seen <= operand_derivation_cycles;
    end
  end

  a_fetch_then_alu: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_10)
    (state == BECS_FETCH && mem_ready) |=> (state == BECS_DECODE && alu_cycle && addr_bus == $past(addr_bus)))
    else $error("fetch not followed by ALU cycle at same address");
  a_alu3_step: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_02)
    (state == BECS_ALU3) |-> (step_num == BECS_STEP_BASE + {4'h0, ns_seen}))
    else $error("ALU step after derivation misnumbered");
  a_deriv_busy: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_02)
    (state == BECS_DERIV) |-> dif.busy)
    else $error("derivation cycle with idle timer");
  a_exec_redecode: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_01)
    (state == BECS_ALU3 && instr[15:6] == BECS_OP_EXEC) |=> (state == BECS_DECODE && instr == $past(sd)))
    else $error("execute did not take up operand instruction");
  a_branch_end: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_03)
    (state == BECS_ALU3 && instr[15:6] == BECS_OP_BRANCH) |=> (pc_load && seq_done && pc_value == $past(sa)))
    else $error("branch did not end after one ALU cycle");
  a_link_write: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_04)
    (state == BECS_BL4) |=> (mem_wr && addr_bus == $past(addr_bus) && data_bus_value == $past(ret_addr)))
    else $error("link write wrong");
  a_status_save: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_05)
    (state == BECS_BW5W) |-> (mem_wr && step_num == 8'h05 + {4'h0, ns_seen} && data_bus_value == $past(status_reg)))
    else $error("status save wrong");
  a_ret_save: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_06)
    $rose(state == BECS_BW7W) |-> (mem_wr && addr_bus == becs_wr_addr(sd, BECS_WR_OLD_PC)
      && step_num == 8'h07 + {4'h0, ns_seen}))
    else $error("return address save wrong");
  a_wp_save: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_07)
    (state == BECS_BW8) |-> (alu_cycle && addr_bus == becs_wr_addr(sd, BECS_WR_OLD_WP))
      ##1 (mem_wr && addr_bus == $past(addr_bus) && data_bus_value == wp)) // see (RULE_08)
    else $error("old pointer save wrong");
  a_vector_read: assert property (@(posedge core_clk) disable iff (!rst_b) // see (RULE_09)
    (state == BECS_BW10 && alu_cycle) |=> (mem_rd && addr_bus == sa + BECS_VEC_PC_OFS))
    else $error("vector read wrong");

endmodule // becs_sequencer

/* sim/becs_mem_model.sv */
// memory model on the far side of the sequencer bus
module becs_mem_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] addr_bus,
  input wire logic [15:0] data_bus_value,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [3:0] wait_cycles,
  output logic mem_ready,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:1023];
  logic [3:0] wait_cnt;
  logic flip;
  // each access is stretched by wait_cycles edges before it completes
  assign mem_ready = (mem_rd | mem_wr) && (wait_cnt == wait_cycles);
  // unselected data lines toggle, so stale data can never look right
  assign mem_rdata = mem_rd ? mem[addr_bus[10:1]] : {16{flip}};
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      wait_cnt <= ((mem_rd | mem_wr) && !mem_ready) ? wait_cnt + 4'h1 : 4'h0;
      if (mem_wr && mem_ready) begin
        mem[addr_bus[10:1]] <= data_bus_value;
      end
    end
  end
endmodule // becs_mem_model

/* sim/tb_top.sv */
// self-checking bench for the branch/execute cycle sequencer
module tb_top
  import becs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ALU = 3'h4;
  localparam logic [2:0] RD = 3'h2;
  localparam logic [2:0] WR = 3'h1;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic [15:0] pc = 16'h0100;
  logic [15:0] wp = 16'h0200;
  logic [15:0] status_reg = 16'ha5c3;
  logic [3:0] operand_derivation_cycles = 4'h0;
  logic [15:0] source_operand_value = 16'h0000;
  logic [15:0] source_addr = 16'h0040;
  logic [15:0] deriv_addr = 16'h0080;
  logic [15:0] deriv_data = 16'h0000;
  logic deriv_rd = 1'b1;
  logic deriv_wr = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic mem_ready, mem_rd, mem_wr, alu_cycle, seq_busy, seq_done, pc_load, wp_load;
  logic [15:0] mem_rdata, addr_bus, data_bus_value, pc_value, wp_value;
  logic [7:0] step_num;
  logic [42:0] rec [$];
  int ix;
  int mismatches = 0;
  int n_checks = 0;

  always #10 core_clk = ~core_clk;

  becs_sequencer uut (.core_clk, .rst_b, .start, .pc, .wp, .status_reg, .operand_derivation_cycles,
    .source_operand_value, .source_addr, .deriv_addr, .deriv_data, .deriv_rd, .deriv_wr, .mem_ready,
    .mem_rdata, .addr_bus, .data_bus_value, .mem_rd, .mem_wr, .alu_cycle, .step_num, .seq_busy,
    .seq_done, .pc_load, .pc_value, .wp_load, .wp_value);
  becs_mem_model part_mem (.core_clk, .rst_b, .addr_bus, .data_bus_value, .mem_rd, .mem_wr,
    .wait_cycles, .mem_ready, .mem_rdata);

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input logic [42:0] got, input logic [42:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // step 8'hff is ignored; care[1] keeps the address, care[0] the data
  task automatic exp_cyc(input logic [2:0] k, input logic [7:0] s, input logic [15:0] a,
                         input logic [15:0] d, input logic [1:0] care);
    logic [42:0] m;
    logic [42:0] got;
    m = {3'h7, {8{s != 8'hff}}, {16{care[1]}}, {16{care[0]}}};
    got = 43'bx;
    if (ix < rec.size()) begin
      got = rec[ix];
    end
    chk_cyc(got & m, {k, s, a, d} & m);
    ix++;
  endtask

  // one completed bus cycle is recorded per entry, wait states folded away
  task automatic run_seq(input logic [15:0] instr, input logic [3:0] ns, input logic [15:0] sd,
                         input logic [3:0] wt);
    int n;
    @(negedge core_clk);
    part_mem.mem[pc[10:1]] = instr;
    operand_derivation_cycles = ns;
    source_operand_value = sd;
    wait_cycles = wt;
    start = 1'b1;
    rec.delete();
    ix = 0;
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (seq_done !== 1'b1 && n < 300) begin
      if (seq_busy === 1'b1 && (alu_cycle === 1'b1 || mem_ready === 1'b1)) begin
        rec.push_back({alu_cycle, mem_rd, mem_wr, step_num, addr_bus, data_bus_value});
      end
      @(negedge core_clk);
      n++;
    end
    chk_word({15'h0000, seq_done}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_branch();
    run_seq({BECS_OP_BRANCH, 6'h00}, 4'h1, 16'h5a5a, 4'h0);
    exp_cyc(RD, 8'h01, pc, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h02, pc, 16'h5a5a, 2'h3);
    exp_cyc(RD, 8'h03, deriv_addr, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h04, 16'h0000, 16'h5a5a, 2'h1);
    chk_word(16'(rec.size()), 16'(ix));
    chk_word({pc_load, wp_load, 14'h0000}, 16'h8000);
    chk_word(pc_value, source_addr);
  endtask

  task automatic t_link();
    run_seq({BECS_OP_LINK, 6'h00}, 4'h2, 16'h3c3c, 4'h1);
    exp_cyc(RD, 8'h01, pc, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h02, pc, 16'h3c3c, 2'h3);
    exp_cyc(RD, 8'h03, deriv_addr, 16'h0000, 2'h2);
    exp_cyc(RD, 8'h04, deriv_addr, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h05, 16'h0000, 16'h3c3c, 2'h1);
    exp_cyc(ALU, 8'h06, wp + 16'h0016, 16'h3c3c, 2'h3);
    exp_cyc(WR, 8'h07, wp + 16'h0016, pc + 16'h0002, 2'h3);
    chk_word(16'(rec.size()), 16'(ix));
    chk_word(pc_value, source_addr);
    chk_word(part_mem.mem[10'h10b], pc + 16'h0002);
  endtask

  task automatic t_exec();
    run_seq({BECS_OP_EXEC, 6'h00}, 4'h0, 16'h0440, 4'h0);
    exp_cyc(RD, 8'h01, pc, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h02, pc, 16'h0440, 2'h3);
    exp_cyc(ALU, 8'h03, 16'h0000, 16'h0440, 2'h1);
    exp_cyc(ALU, 8'h02, 16'h0000, 16'h0440, 2'h1);
    exp_cyc(ALU, 8'h03, 16'h0000, 16'h0440, 2'h1);
    chk_word(16'(rec.size()), 16'(ix));
    chk_word({pc_load, wp_load, 14'h0000}, 16'h8000);
    chk_word(pc_value, source_addr);
  endtask

  // new workspace at 16'h0300, so its registers 13..15 sit at 031a..031e
  task automatic t_ctx(input logic [3:0] wt);
    part_mem.mem[10'h021] = 16'h1234;
    for (int i = 10'h18d; i <= 10'h18f; i++) begin
      part_mem.mem[i] = 16'hffff;
    end
    run_seq({BECS_OP_CTXSW, 6'h00}, 4'h0, 16'h0300, wt);
    exp_cyc(RD, 8'h01, pc, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h02, pc, 16'h0300, 2'h3);
    exp_cyc(ALU, 8'h03, 16'h0000, 16'h0300, 2'h1);
    exp_cyc(ALU, 8'h04, 16'h031e, 16'h0000, 2'h2);
    exp_cyc(WR, 8'h05, 16'h031e, status_reg, 2'h3);
    exp_cyc(ALU, 8'h06, 16'h0000, pc + 16'h0002, 2'h1);
    exp_cyc(WR, 8'h07, 16'h031c, pc + 16'h0002, 2'h3);
    exp_cyc(ALU, 8'h08, 16'h031a, 16'h0300, 2'h3);
    exp_cyc(WR, 8'h09, 16'h031a, wp, 2'h3);
    exp_cyc(ALU, 8'h0a, 16'h0000, 16'h0300, 2'h1);
    exp_cyc(RD, 8'h0b, source_addr + 16'h0002, 16'h0000, 2'h2);
    exp_cyc(ALU, 8'h0c, 16'h0000, 16'h0300, 2'h1);
    chk_word(16'(rec.size()), 16'(ix));
    chk_word({pc_load, wp_load, 14'h0000}, 16'hc000);
    chk_word(pc_value, 16'h1234);
    chk_word(wp_value, 16'h0300);
    chk_word(part_mem.mem[10'h18f], status_reg);
    chk_word(part_mem.mem[10'h18e], pc + 16'h0002);
    chk_word(part_mem.mem[10'h18d], wp);
  endtask

  // reset dropped in the middle of a context switch; the next sequence must start clean
  task automatic t_reset_mid();
    @(negedge core_clk);
    part_mem.mem[pc[10:1]] = {BECS_OP_CTXSW, 6'h00};
    operand_derivation_cycles = 4'h0;
    wait_cycles = 4'h0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b0;
    #1;
    chk_word({seq_busy, mem_rd, mem_wr, seq_done, pc_load, wp_load, 2'b00, step_num}, 16'h0000);
    @(negedge core_clk);
    rst_b = 1'b1;
  endtask

  initial begin
    repeat (2) @(negedge core_clk);
    chk_word({seq_busy, mem_rd, mem_wr, addr_bus[12:0]}, 16'h0000);
    rst_b = 1'b1;
    t_branch();
    t_link();
    t_exec();
    t_ctx(4'h0);
    t_ctx(4'h2);
    t_reset_mid();
    t_branch();
    give_verdict();
  end

  // whole run needs well under 300 cycles
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule // tb_top
